// >>> logic/tss_pkg.sv
// Shared constants, register map and state types of the trigger step sequencer.
package tss_pkg;

  // Bus and data widths.
  localparam int unsigned PADDR_W    = 8;
  localparam int unsigned VAL_W      = 16;
  localparam int unsigned PTR_W      = 5;
  localparam int unsigned ADC_SEL_W  = 5;
  localparam int unsigned TRIG_IN_N  = 16;
  localparam int unsigned TRIG_OUT_N = 32;
  localparam int unsigned IRQ_N      = 16;
  localparam int unsigned QUE_WORDS  = 8;
  localparam int unsigned QUE_SLOTS  = 16;

  // Register byte offsets.
  localparam logic [PADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_PTR    = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_ADJ    = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_HOLD   = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_LIM0   = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_LIM1   = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_CNT0   = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_CNT1   = 8'h1C;
  localparam logic [PADDR_W-1:0] OFF_ADCSEL = 8'h40;
  // Queue words sit at 0x20 + 4*x; bits 7:5 of the address pick the group.
  localparam logic [2:0]         QUE_GRP    = 3'h1;

  // Control register fields.
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RUN_BIT   = 1;
  localparam int unsigned CTRL_STATE_LSB = 2;

  // Reset values.
  localparam logic [PTR_W-1:0]     PTR_RST  = 5'h00;
  localparam logic [VAL_W-1:0]     VAL_RST  = 16'h0000;
  localparam logic [ADC_SEL_W-1:0] ADC_RST  = 5'h00;

  // Command groups, taken from bits 7:5 of a step byte.
  localparam logic [2:0] GRP_CTRL_ADD = 3'h0;
  localparam logic [2:0] GRP_STRB     = 3'h1;
  localparam logic [2:0] GRP_WAIT     = 3'h2;
  localparam logic [2:0] GRP_IRQ      = 3'h3;
  localparam logic [2:0] GRP_TRIG     = 3'h4;
  localparam logic [2:0] GRP_JMP      = 3'h5;
  localparam logic [2:0] GRP_JC0      = 3'h6;
  localparam logic [2:0] GRP_JC1      = 3'h7;

  // Option codes of the control and arithmetic commands.
  localparam logic [3:0] OPT_CLR_CNT  = 4'h1;
  localparam logic [3:0] OPT_STOP     = 4'h2;
  localparam int unsigned OPT_COPY_BIT = 3;
  localparam logic [2:0] TGT_LIM0     = 3'h0;
  localparam logic [2:0] TGT_LIM1     = 3'h1;
  localparam logic [2:0] TGT_CNT0     = 3'h2;
  localparam logic [2:0] TGT_CNT1     = 3'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } tss_state_e;

  typedef struct packed {
    logic                  enable;
    logic                  run;
    logic                  busy;
    logic [PTR_W-1:0]      ptr;
    logic [VAL_W-1:0]      adj;
    logic [VAL_W-1:0]      hold;
    logic [VAL_W-1:0]      lim0;
    logic [VAL_W-1:0]      lim1;
    logic [VAL_W-1:0]      cnt0;
    logic [VAL_W-1:0]      cnt1;
    logic [ADC_SEL_W-1:0]  adcSel;
    logic [IRQ_N-1:0]      irq;
    logic [TRIG_OUT_N-1:0] trig;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    tss_state_e            state;
  } tss_core_s;

  typedef struct packed {
    logic [TRIG_IN_N-1:0] prev;
  } tss_edge_s;

  typedef struct packed {
    logic [QUE_SLOTS-1:0][7:0] slot;
  } tss_queue_s;

endpackage

// >>> logic/tss_edge_detect.sv
// Rise and fall detection on the trigger inputs.
`timescale 1ns/1ns
module tss_edge_detect
  import tss_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 srst,
  // Trigger levels and their edges.
  input  wire logic [TRIG_IN_N-1:0] sig,
  output logic      [TRIG_IN_N-1:0] rise,
  output logic      [TRIG_IN_N-1:0] fall
);

  tss_edge_s r_reg;
  tss_edge_s r_next;

  always_comb begin
    r_next.prev = sig;
    rise        = sig & ~r_reg.prev;
    fall        = ~sig & r_reg.prev;
  end

  // Previous level resets to zero, so an input high at release counts as a rise.
  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// >>> logic/tss_step_queue.sv
// Sixteen step-command bytes, written as eight 16-bit words.
`timescale 1ns/1ns
module tss_step_queue
  import tss_pkg::*;
(
  // Clock.
  input  wire logic        clock,
  // Word write port.
  input  wire logic        wrEn,
  input  wire logic [2:0]  wrIdx,
  input  wire logic [15:0] wrData,
  // Read ports.
  input  wire logic [2:0]  rdIdx,
  output logic      [15:0] rdWord,
  input  wire logic [3:0]  stepIdx,
  output logic      [7:0]  stepByte
);

  tss_queue_s r_reg;
  tss_queue_s r_next;

  always_comb begin
    r_next = r_reg;
    for (int w = 0; w < QUE_WORDS; w++) begin
      if (wrEn && (wrIdx == 3'(w))) begin
        r_next.slot[2*w]   = wrData[7:0];
        r_next.slot[2*w+1] = wrData[15:8];
      end
    end
    rdWord   = {r_reg.slot[{rdIdx, 1'b1}], r_reg.slot[{rdIdx, 1'b0}]};
    stepByte = r_reg.slot[stepIdx];
  end

  // No reset here: the program survives every reset source.
  always_ff @(posedge clock) begin
    r_reg <= r_next;
  end

endmodule

// >>> logic/trigger_step_sequencer.sv
// Trigger step sequencer: APB registers, step decode and execution.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module trigger_step_sequencer
  import tss_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  srst,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PADDR_W-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Trigger sources and consumers.
  input  wire logic [TRIG_IN_N-1:0]  trigIn,
  output logic      [TRIG_OUT_N-1:0] trigOut,
  output logic      [IRQ_N-1:0]      irqOut,
  output logic      [ADC_SEL_W-1:0]  adcChannelSelect,
  output logic                       busy
);

  tss_core_s r_reg;
  tss_core_s r_next;

  logic                 running;
  logic [7:0]           stepByte;
  logic [3:0]           cmd;
  logic [3:0]           opt;
  logic [PTR_W-1:0]     target;
  logic [PTR_W-1:0]     ptrInc;
  logic [TRIG_IN_N-1:0] rise;
  logic [TRIG_IN_N-1:0] fall;
  logic                 qWrEn;
  logic [15:0]          qRdWord;
  logic                 qHit;
  logic                 mapped;
  logic [31:0]          rdMux;
  logic                 setupPh;
  logic                 accessPh;
  logic [VAL_W-1:0]     operand;
  logic [VAL_W-1:0]     tgtOld;
  logic [VAL_W-1:0]     tgtNew;

  tss_edge_detect u_edge (
    .clock (clock),
    .srst  (srst),
    .sig   (trigIn),
    .rise  (rise),
    .fall  (fall)
  );

  tss_step_queue u_queue (
    .clock    (clock),
    .wrEn     (qWrEn),
    .wrIdx    (paddr[4:2]),
    .wrData   (pwdata[15:0]),
    .rdIdx    (paddr[4:2]),
    .rdWord   (qRdWord),
    .stepIdx  (r_reg.ptr[3:0]),
    .stepByte (stepByte)
  );

  assign running  = r_reg.enable & r_reg.run;
  assign cmd      = stepByte[7:4];
  assign opt      = stepByte[3:0];
  assign target   = {cmd[0], opt};
  assign ptrInc   = r_reg.ptr + PTR_W'(1);
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable & r_reg.pready;
  assign qHit     = (paddr[7:5] == QUE_GRP) && (paddr[1:0] == 2'h0);

  // Add and copy share one target decode; bit 3 of the option picks copy.
  always_comb begin
    operand = opt[OPT_COPY_BIT] ? r_reg.hold : r_reg.adj;
    unique case (opt[2:0])
      TGT_LIM0: tgtOld = r_reg.lim0;
      TGT_LIM1: tgtOld = r_reg.lim1;
      TGT_CNT0: tgtOld = r_reg.cnt0;
      TGT_CNT1: tgtOld = r_reg.cnt1;
      default:  tgtOld = VAL_RST;
    endcase
    tgtNew = opt[OPT_COPY_BIT] ? operand : VAL_W'(tgtOld + operand);
  end

  // Read decode; the value is captured in the setup cycle.
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h00000000;
    if (qHit) begin
      rdMux = {16'h0000, qRdWord};
    end else begin
      unique case (paddr)
        OFF_CTRL:   rdMux = {28'h0000000, r_reg.state, r_reg.run, r_reg.enable};
        OFF_PTR:    rdMux = {27'h0000000, r_reg.ptr};
        OFF_ADJ:    rdMux = {16'h0000, r_reg.adj};
        OFF_HOLD:   rdMux = {16'h0000, r_reg.hold};
        OFF_LIM0:   rdMux = {16'h0000, r_reg.lim0};
        OFF_LIM1:   rdMux = {16'h0000, r_reg.lim1};
        OFF_CNT0:   rdMux = {16'h0000, r_reg.cnt0};
        OFF_CNT1:   rdMux = {16'h0000, r_reg.cnt1};
        OFF_ADCSEL: rdMux = {27'h0000000, r_reg.adcSel};
        default:    mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    r_next         = r_reg;
    r_next.irq     = '0;
    r_next.trig    = '0;
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    qWrEn          = 1'b0;

    // One step per clock; a wait holds the pointer in place.
    if (running) begin
      r_next.state = ST_EXEC;
      r_next.ptr   = ptrInc;
      unique case (cmd[3:1])
        GRP_CTRL_ADD: begin
          if (cmd[0]) begin
            if (opt[2:0] == TGT_LIM0) r_next.lim0 = tgtNew;
            if (opt[2:0] == TGT_LIM1) r_next.lim1 = tgtNew;
            if (opt[2:0] == TGT_CNT0) r_next.cnt0 = tgtNew;
            if (opt[2:0] == TGT_CNT1) r_next.cnt1 = tgtNew;
          end else if (opt == OPT_CLR_CNT) begin
            r_next.cnt0 = VAL_RST;
            r_next.cnt1 = VAL_RST;
          end else if (opt == OPT_STOP) begin
            r_next.run = 1'b0;
          end
        end
        GRP_STRB: begin
          r_next.adcSel = target;
        end
        GRP_WAIT: begin
          if (cmd[0] ? !fall[opt] : !rise[opt]) begin
            r_next.ptr   = r_reg.ptr;
            r_next.state = ST_WAIT;
          end
        end
        GRP_IRQ: begin
          // Code 0110 falls through with only the pointer advance.
          if (cmd[0]) r_next.irq[opt] = 1'b1;
        end
        GRP_TRIG: begin
          r_next.trig[target] = 1'b1;
        end
        GRP_JMP: begin
          r_next.ptr = target;
        end
        GRP_JC0: begin
          if (r_reg.cnt0 != r_reg.lim0) begin
            r_next.cnt0 = r_reg.cnt0 + VAL_W'(1);
            r_next.ptr  = target;
          end
        end
        GRP_JC1: begin
          if (r_reg.cnt1 != r_reg.lim1) begin
            r_next.cnt1 = r_reg.cnt1 + VAL_W'(1);
            r_next.ptr  = target;
          end
        end
      endcase
    end else begin
      r_next.state = ST_IDLE;
    end

    // Bus answer is prepared in setup so the access phase ends at once.
    if (setupPh) begin
      r_next.prdata  = rdMux;
      r_next.pready  = 1'b1;
      r_next.pslverr = ~mapped;
    end

    // Software writes other than the pointer and the queue land after the step so they win a same-cycle clash.
    if (accessPh && pwrite) begin
      if (qHit) begin
        qWrEn = ~running;
      end else begin
        unique case (paddr)
          OFF_CTRL: begin
            r_next.enable = pwdata[CTRL_EN_BIT];
            r_next.run    = pwdata[CTRL_RUN_BIT];
          end
          OFF_PTR: begin
            if (!running) r_next.ptr = pwdata[PTR_W-1:0];
          end
          OFF_ADJ:  r_next.adj  = pwdata[VAL_W-1:0];
          OFF_HOLD: r_next.hold = pwdata[VAL_W-1:0];
          OFF_LIM0: r_next.lim0 = pwdata[VAL_W-1:0];
          OFF_LIM1: r_next.lim1 = pwdata[VAL_W-1:0];
          OFF_CNT0: r_next.cnt0 = pwdata[VAL_W-1:0];
          OFF_CNT1: r_next.cnt1 = pwdata[VAL_W-1:0];
          default: begin
          end
        endcase
      end
    end

    // Busy is registered from the next state so the pin comes straight from a flop.
    r_next.busy = r_next.enable & r_next.run;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg         <= '0;
      r_reg.ptr     <= PTR_RST;
      r_reg.adcSel  <= ADC_RST;
      r_reg.state   <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata           = r_reg.prdata;
  assign pready           = r_reg.pready;
  assign pslverr          = r_reg.pslverr;
  assign trigOut          = r_reg.trig;
  assign irqOut           = r_reg.irq;
  assign adcChannelSelect = r_reg.adcSel;
  assign busy             = r_reg.busy;

  // A new address in the next cycle legitimately changes the read word.
  a_queue_write_lock: assert property (
    @(posedge clock) disable iff (srst)
    (running && accessPh && pwrite && qHit)
    |=> (qRdWord == $past(qRdWord)) || $changed(paddr))
    else $error("Queue written while sequencer runs.");

  a_ptr_write_lock: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h4 && !rise[opt] && accessPh && pwrite && paddr == OFF_PTR)
    |=> r_reg.ptr == $past(r_reg.ptr))
    else $error("Pointer write took effect while running.");

  a_strobe_adc_sel: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd[3:1] == GRP_STRB) |=> adcChannelSelect == $past(target))
    else $error("Channel select not loaded by strobe step.");

  a_wait_rise_hold: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h4 && !rise[opt]) |=> r_reg.ptr == $past(r_reg.ptr))
    else $error("Rise wait advanced without an edge.");

  a_wait_fall_go: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h5 && fall[opt] && !(accessPh && pwrite))
    |=> r_reg.ptr == $past(ptrInc))
    else $error("Fall wait did not advance on the edge.");

  a_reserved_nop: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h6 && !(accessPh && pwrite))
    |=> (r_reg.ptr == $past(ptrInc)) && (irqOut == '0) && (trigOut == '0))
    else $error("Reserved step did more than advance.");

  a_irq_pulse_one: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h7) |=> (irqOut == (IRQ_N'(1) << $past(opt)))
    ##1 (!irqOut[$past(opt, 2)] || $past(running && cmd == 4'h7)))
    else $error("Interrupt pulse wrong or too long.");

  a_trig_out_pulse: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd[3:1] == GRP_TRIG) |=> $onehot(trigOut) && trigOut[$past(target)])
    else $error("Trigger output pulse wrong.");

  a_jump_loads_ptr: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd[3:1] == GRP_JMP) |=> r_reg.ptr == $past(target))
    else $error("Jump did not load the pointer.");

  a_loop0_limit: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd[3:1] == GRP_JC0 && r_reg.cnt0 != r_reg.lim0 && !(accessPh && pwrite))
    |=> (r_reg.cnt0 == $past(r_reg.cnt0) + VAL_W'(1)) && (r_reg.ptr == $past(target)))
    else $error("Loop 0 jump wrong.");

  a_loop1_at_limit: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd[3:1] == GRP_JC1 && r_reg.cnt1 == r_reg.lim1 && !(accessPh && pwrite))
    |=> (r_reg.ptr == $past(ptrInc)) && $stable(r_reg.cnt1))
    else $error("Loop 1 at limit did not just advance.");

  a_ptr_idle_hold: assert property (
    @(posedge clock) disable iff (srst)
    (!running && !(accessPh && pwrite && paddr == OFF_PTR))
    |=> r_reg.ptr == $past(r_reg.ptr))
    else $error("Pointer moved while the sequencer was idle.");

  a_ptr_step_inc: assert property (
    @(posedge clock) disable iff (srst)
    (running && (cmd[3:1] == GRP_STRB || cmd[3:1] == GRP_TRIG || cmd == 4'h7))
    |=> r_reg.ptr == $past(ptrInc))
    else $error("Pointer did not advance after a step.");

  a_clear_counters: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h0 && opt == OPT_CLR_CNT && !(accessPh && pwrite))
    |=> (r_reg.cnt0 == VAL_RST) && (r_reg.cnt1 == VAL_RST))
    else $error("Counter clear step left a counter set.");

  a_stop_clears_run: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h0 && opt == OPT_STOP && !(accessPh && pwrite))
    |=> !busy && (r_reg.ptr == $past(ptrInc)))
    else $error("Stop step did not halt the sequencer.");

  a_add_adjust: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h1 && opt == {1'b0, TGT_CNT0} && !(accessPh && pwrite))
    |=> r_reg.cnt0 == VAL_W'($past(r_reg.cnt0) + $past(r_reg.adj)))
    else $error("Add step gave a wrong counter value.");

  a_copy_hold: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h1 && opt == {1'b1, TGT_LIM0} && !(accessPh && pwrite))
    |=> r_reg.lim0 == $past(r_reg.hold))
    else $error("Copy step did not load the hold value.");

  a_wait_fall_hold: assert property (
    @(posedge clock) disable iff (srst)
    (running && cmd == 4'h5 && !fall[opt]) |=> r_reg.ptr == $past(r_reg.ptr))
    else $error("Fall wait advanced without an edge.");

endmodule

// >>> bench/tss_trigger_partner.sv
// Model of the trigger sources and consumers around the step sequencer.
`timescale 1ns/1ns
module tss_trigger_partner
  import tss_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Levels the bench wants on the trigger sources.
  input  wire logic [TRIG_IN_N-1:0]  levelCmd,
  // Sequencer side.
  output logic      [TRIG_IN_N-1:0]  trigIn,
  input  wire logic [TRIG_OUT_N-1:0] trigOut,
  input  wire logic [IRQ_N-1:0]      irqOut,
  // Pulse counts seen so far.
  output int                         trigCount [TRIG_OUT_N],
  output int                         irqCount  [IRQ_N]
);
  // Sources change only just after an edge, so the sequencer samples a settled level.
  always @(posedge clock) begin
    trigIn <= levelCmd;
    for (int i = 0; i < TRIG_OUT_N; i++) begin
      trigCount[i] <= srst ? 0 : trigCount[i] + int'(trigOut[i] === 1'b1);
    end
    for (int i = 0; i < IRQ_N; i++) begin
      irqCount[i] <= srst ? 0 : irqCount[i] + int'(irqOut[i] === 1'b1);
    end
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench of the trigger step sequencer over its register bus.
`timescale 1ns/1ns
module tb_top
  import tss_pkg::*;
;
  logic                  clock;
  logic                  srst;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [PADDR_W-1:0]    paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [TRIG_IN_N-1:0]  trigIn;
  logic [TRIG_IN_N-1:0]  levelCmd;
  logic [TRIG_OUT_N-1:0] trigOut;
  logic [IRQ_N-1:0]      irqOut;
  logic [ADC_SEL_W-1:0]  adcChannelSelect;
  logic                  busy;
  int                    trigCount [TRIG_OUT_N];
  int                    irqCount  [IRQ_N];
  int                    miscompares;
  int                    comparisons;
  logic [31:0]           rdVal;
  logic                  rdErr;
  logic [15:0]           prog [QUE_WORDS];

  trigger_step_sequencer dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigIn(trigIn), .trigOut(trigOut), .irqOut(irqOut),
    .adcChannelSelect(adcChannelSelect), .busy(busy));

  tss_trigger_partner far (.clock(clock), .srst(srst), .levelCmd(levelCmd), .trigIn(trigIn),
    .trigOut(trigOut), .irqOut(irqOut), .trigCount(trigCount), .irqCount(irqCount));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // One transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      chk(32'h0000_0BAD, 32'h0000_0000);
    end
    rdVal = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdVal, exp);
  endtask

  // Polls a register until it shows the wanted value, bounded.
  task automatic poll(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0000_0000);
    while ((rdVal & mask) !== exp && n < 100) begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end
    chk(rdVal & mask, exp);
  endtask

  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    miscompares++;
    stop_test();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    levelCmd = '0;
    miscompares = 0;
    comparisons = 0;
    // Slots: strobe, trigger 5, irq 3, reserved, rise 2, fall 1, add, copy,
    // trigger 31, loop0 to 8, loop1 to 0, jump 13, trigger 4 (skipped), clear counters, stop.
    prog = '{16'h853A, 16'h6073, 16'h5142, 16'h1812, 16'hC89F, 16'hADE0, 16'h0184, 16'h0002};
    repeat (5) @(posedge clock);
    srst <= 1'b0;

    foreach (prog[i]) rd(OFF_CTRL + 8'(4 * i), 32'h0000_0000);
    rd(OFF_ADCSEL, 32'h0000_0000);
    apb(1'b0, 8'h80, 32'h0000_0000);
    chk({31'h0, rdErr}, 32'h0000_0001);
    chk(rdVal, 32'h0000_0000);
    $display("Test reset values done");

    foreach (prog[i]) wr(OFF_CTRL + 8'h20 + 8'(4 * i), {16'h0000, prog[i]});
    foreach (prog[i]) rd(OFF_CTRL + 8'h20 + 8'(4 * i), {16'h0000, prog[i]});
    wr(OFF_PTR, 32'h0000_0013);
    rd(OFF_PTR, 32'h0000_0013);
    wr(OFF_PTR, 32'h0000_0000);
    wr(OFF_ADJ, 32'h0000_0001);
    wr(OFF_HOLD, 32'h0000_0003);
    levelCmd[1] <= 1'b1;
    $display("Test queue programming done");

    wr(OFF_CTRL, 32'h0000_0003);
    poll(OFF_PTR, 32'h0000_001F, 32'h0000_0004);
    rd(OFF_CTRL, 32'h0000_000B);
    rd(OFF_ADCSEL, 32'h0000_001A);
    chk(32'(trigCount[5]), 32'h0000_0001);
    chk(32'(irqCount[3]), 32'h0000_0001);
    chk({31'h0, busy}, 32'h0000_0001);
    chk({27'h0, adcChannelSelect}, 32'h0000_001A);
    wr(OFF_PTR, 32'h0000_0000);
    wr(8'h20, 32'h0000_FFFF);
    rd(OFF_PTR, 32'h0000_0004);
    rd(8'h20, {16'h0000, prog[0]});
    levelCmd[2] <= 1'b1;
    poll(OFF_PTR, 32'h0000_001F, 32'h0000_0005);
    levelCmd[1] <= 1'b0;
    poll(OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
    chk({31'h0, busy}, 32'h0000_0000);
    rd(OFF_PTR, 32'h0000_000F);
    rd(OFF_CNT0, 32'h0000_0000);
    rd(OFF_LIM0, 32'h0000_0003);
    rd(OFF_CNT1, 32'h0000_0000);
    chk(32'(trigCount[31]), 32'h0000_0003);
    chk(32'(trigCount[4]), 32'h0000_0000);
    chk(32'(trigCount[0]), 32'h0000_0000);
    rd(OFF_ADCSEL, 32'h0000_001A);
    $display("Test step execution done");

    @(posedge clock);
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    foreach (prog[i]) rd(OFF_CTRL + 8'h20 + 8'(4 * i), {16'h0000, prog[i]});
    rd(OFF_PTR, 32'h0000_0000);
    chk({27'h0, adcChannelSelect}, 32'h0000_0000);
    $display("Test queue retention done");
    stop_test();
  end
endmodule
